// File: tmcu_top.sv
// Module: 8-bit timer/counter with two compare units behind AXI4-Lite
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Counter and compare registers are 8 bits
// - Tick from prescaler or external pin edge
// - Select zero stops the counter
// - Counter readable and writable at any time
// - Software counter write beats counting
// - Each tick clears, increments or decrements
// - Bottom is 0x00, max is 0xFF
// - Top is 0xFF or compare A
// - Mode field split across both controls
// - Wrap flag set per mode, can interrupt
// - Comparators match counter against each compare
// - Match flag set on next tick
// - Servicing interrupt clears its match flag
// - Writing one clears a flag
// - Three flags, each individually maskable
// - Compare double buffered only in PWM modes
// - Buffer copied to compare at top
// - Without buffering, writes reach compare directly
// - Force strobe acts as match in non-PWM modes only, no flag
// - Counter write blocks matches next tick
// - Output modes immediate, output state kept
// - Normal mode wraps, flag when zero
// - Clear-on-match mode clears at compare A
// - Fast PWM single slope to top
// - Reset forces output state to zero
module tmcu_top
  import tmcu_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_count_pin,
  input wire logic [2:0] int_ack,
  output logic [2:0] irq_req,
  output logic [1:0] compare_out,
  output logic [1:0] compare_out_en
);

  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Bus slave state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_have_q, w_have_q, w_strb0_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] rd_byte;
  logic [TMCU_NREG-1:0] wsel, rsel;
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire ar_take = s_axi_arvalid & arready_q;
  wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  wire wr_en = wr_fire & w_strb0_q;
  wire aw_have_d = aw_take | (aw_have_q & ~wr_fire);
  wire w_have_d = w_take | (w_have_q & ~wr_fire);
  wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
  wire [ADDR_W-1:0] aw_word = {aw_addr_q[ADDR_W-1:2], 2'b00};
  wire [ADDR_W-1:0] ar_word = {s_axi_araddr[ADDR_W-1:2], 2'b00};

  for (genvar r = 0; r < TMCU_NREG; r++) begin : g_dec
    assign wsel[r] = aw_word == ADDR_W'(TMCU_OFS[r]);
    assign rsel[r] = ar_word == ADDR_W'(TMCU_OFS[r]);
  end

  // Timer state
  tmcu_ctrl_a_t ctrl_a_q;
  tmcu_ctrl_b_t ctrl_b_q;
  tmcu_irq_t flags_q, flags_d, mask_q, irq_q, flag_set, flag_clr;
  tmcu_dir_t dir_q, dir_d;
  logic [7:0] cnt_q, cnt_d, cnt_nx;
  logic [7:0] cmp_q [2];
  logic [7:0] buf_q [2];
  logic [1:0] oc_q, oc_en_q, eq, mev, force_m;
  logic [9:0] pre_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic block_q, tick;

  wire [2:0] mode = {ctrl_b_q.wgm2, ctrl_a_q.wgm_lo};
  // Odd modes are the PWM modes; bit 1 tells fast from phase correct
  wire pwm = mode[0];
  wire fast = mode[0] & mode[1];
  wire phase = mode[0] & ~mode[1];
  wire top_is_a = (mode == TMCU_WG_CTC) | (mode[2] & mode[0]);
  wire [7:0] top = top_is_a ? cmp_q[0] : TMCU_MAX;
  wire at_top = cnt_q == top;
  wire at_bot = cnt_q == TMCU_BOTTOM;
  wire at_max = cnt_q == TMCU_MAX;
  wire sw_cnt_wr = wr_en & wsel[TMCU_R_COUNT];
  wire ctrl_b_wr = wr_en & wsel[TMCU_R_CTRL_B];
  wire going_down = (dir_q == TMCU_DIR_DOWN) ? ~at_bot : at_top;
  wire load = tick & at_top & pwm;
  wire ext_rise = ext_s2_q & ~ext_s3_q;
  wire ext_fall = ~ext_s2_q & ext_s3_q;

  // Tick source; select zero gives no tick at all
  always_comb
  begin
    case (ctrl_b_q.cs)
      TMCU_CS_STOP: tick = 1'b0;
      TMCU_CS_DIV1: tick = 1'b1;
      TMCU_CS_DIV8: tick = (pre_q & TMCU_PS_M8) == TMCU_PS_M8;
      TMCU_CS_DIV64: tick = (pre_q & TMCU_PS_M64) == TMCU_PS_M64;
      TMCU_CS_DIV256: tick = (pre_q & TMCU_PS_M256) == TMCU_PS_M256;
      TMCU_CS_DIV1024: tick = pre_q == TMCU_PS_M1024;
      TMCU_CS_EXT_FALL: tick = ext_fall;
      TMCU_CS_EXT_RISE: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  // Next count on a tick
  always_comb
  begin
    dir_d = TMCU_DIR_UP;
    if (phase)
    begin
      dir_d = going_down ? TMCU_DIR_DOWN : TMCU_DIR_UP;
      cnt_nx = going_down ? cnt_q - 8'h01 : cnt_q + 8'h01;
    end
    else if (fast | (mode == TMCU_WG_CTC))
      cnt_nx = at_top ? TMCU_BOTTOM : cnt_q + 8'h01;
    else
      cnt_nx = cnt_q + 8'h01;
  end

  // Software write wins over any count step
  assign cnt_d = sw_cnt_wr ? w_data_q : (tick ? cnt_nx : cnt_q);

  assign flag_set.wrap = tick & (fast ? at_top : (phase ? at_bot : at_max));
  assign flag_set.match_a = mev[0];
  assign flag_set.match_b = mev[1];
  assign flag_clr = (wr_en & wsel[TMCU_R_FLAG] ? w_data_q[2:0] : 3'h0) | int_ack;
  // A new event beats a clear in the same cycle
  assign flags_d = (flags_q & ~flag_clr) | flag_set;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_q <= 10'h000;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      cnt_q <= TMCU_RST;
      dir_q <= TMCU_DIR_UP;
      block_q <= 1'b0;
      flags_q <= 3'h0;
      mask_q <= 3'h0;
      irq_q <= 3'h0;
      ctrl_a_q <= TMCU_RST;
      ctrl_b_q <= TMCU_RST;
    end
    else if (ce)
    begin
      pre_q <= pre_q + 10'h001;
      ext_s1_q <= ext_count_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      cnt_q <= cnt_d;
      if (tick)
        dir_q <= dir_d;
      // Blocking lasts until the next tick, even while stopped
      block_q <= sw_cnt_wr | (block_q & ~tick);
      flags_q <= flags_d;
      irq_q <= flags_q & mask_q;
      if (wr_en & wsel[TMCU_R_MASK])
        mask_q <= w_data_q[2:0];
      if (wr_en & wsel[TMCU_R_CTRL_A])
        ctrl_a_q <= {w_data_q[7:4], 2'b00, w_data_q[1:0]};
      if (ctrl_b_wr)
        ctrl_b_q <= {4'h0, w_data_q[3:0]};
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_cmp
    logic [1:0] com;
    logic oc_d;
    wire cmp_wr = wr_en & wsel[TMCU_R_CMP_A + i];
    assign com = (i == 0) ? ctrl_a_q.com_a : ctrl_a_q.com_b;
    assign eq[i] = cnt_q == cmp_q[i];
    assign mev[i] = tick & eq[i] & ~block_q;
    assign force_m[i] = ctrl_b_wr & ~pwm & w_data_q[7 - i];

    // Output mode takes effect at once, it is never buffered
    always_comb
    begin
      oc_d = oc_q[i];
      if (!pwm)
      begin
        if (mev[i] | force_m[i])
        begin
          case (com)
            TMCU_COM_TOGGLE: oc_d = ~oc_q[i];
            TMCU_COM_CLEAR: oc_d = 1'b0;
            TMCU_COM_SET: oc_d = 1'b1;
            default: oc_d = oc_q[i];
          endcase
        end
      end
      else if (com == TMCU_COM_TOGGLE)
      begin
        if (mev[i] && (i == 0) && mode[2])
          oc_d = ~oc_q[i];
      end
      else if (com[1])
      begin
        // Bottom beats a match at top, so compare equal to top keeps the bottom level
        if (fast && tick && at_top)
          oc_d = ~com[0];
        else if (mev[i])
          oc_d = (phase && dir_q == TMCU_DIR_DOWN) ? ~com[0] : com[0];
      end
    end

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        cmp_q[i] <= TMCU_RST;
        buf_q[i] <= TMCU_RST;
        oc_q[i] <= 1'b0;
        oc_en_q[i] <= 1'b0;
      end
      else if (ce)
      begin
        if (cmp_wr)
          buf_q[i] <= w_data_q;
        if (cmp_wr & ~pwm)
          cmp_q[i] <= w_data_q;
        else if (load)
          cmp_q[i] <= buf_q[i];
        oc_q[i] <= oc_d;
        oc_en_q[i] <= com != TMCU_COM_OFF;
      end
    end
  end

  // Read mux; compare reads show the buffer only while it is in use
  always_comb
  begin
    rd_byte = 8'h00;
    if (rsel[TMCU_R_CTRL_A])
      rd_byte = ctrl_a_q;
    if (rsel[TMCU_R_CTRL_B])
      rd_byte = ctrl_b_q;
    if (rsel[TMCU_R_COUNT])
      rd_byte = cnt_q;
    if (rsel[TMCU_R_CMP_A])
      rd_byte = pwm ? buf_q[0] : cmp_q[0];
    if (rsel[TMCU_R_CMP_B])
      rd_byte = pwm ? buf_q[1] : cmp_q[1];
    if (rsel[TMCU_R_MASK])
      rd_byte = {5'h00, mask_q};
    if (rsel[TMCU_R_FLAG])
      rd_byte = {5'h00, flags_q};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 8'h00;
      w_strb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= TMCU_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= TMCU_RESP_OKAY;
    end
    else if (ce)
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= ~aw_have_d;
      wready_q <= ~w_have_d;
      if (aw_take)
        aw_addr_q <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_q <= s_axi_wdata[7:0];
        w_strb0_q <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= (|wsel) ? TMCU_RESP_OKAY : TMCU_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
      rvalid_q <= rvalid_d;
      arready_q <= ~rvalid_d;
      if (ar_take)
      begin
        rdata_q <= {24'h000000, rd_byte};
        rresp_q <= (|rsel) ? TMCU_RESP_OKAY : TMCU_RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq_req = irq_q;
  assign compare_out = oc_q;
  assign compare_out_en = oc_en_q;

  chk_stop_hold: assert property (
    ce && ctrl_b_q.cs == TMCU_CS_STOP && !sw_cnt_wr |=> cnt_q == $past(cnt_q))
    else $error("stopped counter moved");

  chk_write_wins: assert property (
    ce && sw_cnt_wr |=> cnt_q == $past(w_data_q))
    else $error("counter write lost");

  chk_normal_wrap: assert property (
    ce && tick && mode == TMCU_WG_NORMAL && at_max && !sw_cnt_wr
    |=> cnt_q == TMCU_BOTTOM && flags_q.wrap)
    else $error("normal wrap wrong");

  chk_match_flag: assert property (
    ce && tick && eq[0] && !block_q |=> flags_q.match_a)
    else $error("match flag not set");

  chk_write_block: assert property (
    ce && sw_cnt_wr |=> block_q && !mev[0] && !mev[1])
    else $error("match not blocked");

  chk_ctc_clear: assert property (
    ce && tick && mode == TMCU_WG_CTC && at_top && !sw_cnt_wr |=> cnt_q == TMCU_BOTTOM)
    else $error("clear on match missed");

  chk_dbuf_hold: assert property (
    ce && pwm && !load |=> cmp_q[0] == $past(cmp_q[0]))
    else $error("buffered compare changed early");

  chk_force_set: assert property (
    ce && force_m[0] && ctrl_a_q.com_a == TMCU_COM_SET |=> oc_q[0])
    else $error("force did not set output");

  chk_flag_w1c: assert property (
    ce && wr_en && wsel[TMCU_R_FLAG] && w_data_q[1] && !mev[0] |=> !flags_q.match_a)
    else $error("flag not cleared");

endmodule
`default_nettype wire

// File: tmcu_pkg.sv
// Package: register map, field layout and constants of the 8-bit timer
package tmcu_pkg;
  // Register indices and their byte offsets
  localparam int TMCU_NREG = 7;
  localparam int TMCU_R_CTRL_A = 0;
  localparam int TMCU_R_CTRL_B = 1;
  localparam int TMCU_R_COUNT = 2;
  localparam int TMCU_R_CMP_A = 3;
  localparam int TMCU_R_CMP_B = 4;
  localparam int TMCU_R_MASK = 5;
  localparam int TMCU_R_FLAG = 6;
  localparam logic [7:0] TMCU_OFS [TMCU_NREG] = '{8'h00, 8'h04, 8'h08, 8'h0c,
    8'h10, 8'h14, 8'h18};
  localparam logic [7:0] TMCU_RST = 8'h00;
  localparam logic [7:0] TMCU_BOTTOM = 8'h00;
  localparam logic [7:0] TMCU_MAX = 8'hff;
  // Tick source selections
  localparam logic [2:0] TMCU_CS_STOP = 3'h0;
  localparam logic [2:0] TMCU_CS_DIV1 = 3'h1;
  localparam logic [2:0] TMCU_CS_DIV8 = 3'h2;
  localparam logic [2:0] TMCU_CS_DIV64 = 3'h3;
  localparam logic [2:0] TMCU_CS_DIV256 = 3'h4;
  localparam logic [2:0] TMCU_CS_DIV1024 = 3'h5;
  localparam logic [2:0] TMCU_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TMCU_CS_EXT_RISE = 3'h7;
  localparam logic [9:0] TMCU_PS_M8 = 10'h007;
  localparam logic [9:0] TMCU_PS_M64 = 10'h03f;
  localparam logic [9:0] TMCU_PS_M256 = 10'h0ff;
  localparam logic [9:0] TMCU_PS_M1024 = 10'h3ff;
  // Waveform modes
  localparam logic [2:0] TMCU_WG_NORMAL = 3'h0;
  localparam logic [2:0] TMCU_WG_CTC = 3'h2;
  // Compare output modes
  localparam logic [1:0] TMCU_COM_OFF = 2'h0;
  localparam logic [1:0] TMCU_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TMCU_COM_CLEAR = 2'h2;
  localparam logic [1:0] TMCU_COM_SET = 2'h3;
  localparam logic [1:0] TMCU_RESP_OKAY = 2'h0;
  localparam logic [1:0] TMCU_RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [1:0] rsvd;
    logic [1:0] wgm_lo;
  } tmcu_ctrl_a_t;
  typedef struct packed {
    logic force_a;
    logic force_b;
    logic [1:0] rsvd;
    logic wgm2;
    logic [2:0] cs;
  } tmcu_ctrl_b_t;
  typedef struct packed {
    logic match_b;
    logic match_a;
    logic wrap;
  } tmcu_irq_t;
  typedef enum logic {TMCU_DIR_UP, TMCU_DIR_DOWN} tmcu_dir_t;
endpackage

// File: tmcu_pin_model.sv
// Far-side pin model: drives the external count input of the timer
`timescale 1ns/1ns
`default_nettype none
module tmcu_pin_model (
  input wire logic clk,
  output logic count_pin
);
  initial count_pin = 1'b0;
  // Each level held 3 cycles, above the 2-cycle minimum the synchroniser needs
  task automatic pulse(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge clk);
      count_pin <= 1'b1;
      repeat (3) @(posedge clk);
      count_pin <= 1'b0;
    end
    // Let the synchroniser and counter settle before software looks
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: timer8_counter_compare_unit_tb_top.sv
// Testbench: AXI4-Lite register tests of the 8-bit timer
`timescale 1ns/1ns
`default_nettype none
module timer8_counter_compare_unit_tb_top;
  import tmcu_pkg::*;
  localparam logic [7:0] A_CA = 8'h00;
  localparam logic [7:0] A_CB = 8'h04;
  localparam logic [7:0] A_CNT = 8'h08;
  localparam logic [7:0] A_CPA = 8'h0c;
  localparam logic [7:0] A_CPB = 8'h10;
  localparam logic [7:0] A_MSK = 8'h14;
  localparam logic [7:0] A_FLG = 8'h18;
  localparam logic [1:0] OK = TMCU_RESP_OKAY;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, ext_pin;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, cmp_out, cmp_en;
  logic [2:0] int_ack, irq;
  logic ce;
  logic [3:0] strb;
  int mismatches, checks_done;
  tmcu_top u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_count_pin(ext_pin), .int_ack(int_ack),
    .irq_req(irq), .compare_out(cmp_out), .compare_out_en(cmp_en));
  tmcu_pin_model u_pins (.clk(aclk), .count_pin(ext_pin));
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    while (bvalid !== 1'b1) @(posedge aclk);
    chk(bresp, er);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk(rdata, {24'h000000, exp});
    chk(rresp, er);
    rready <= 1'b0;
  endtask
  task automatic results();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    mismatches++;
    results();
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    int_ack = 3'h0;
    ce = 1'b1;
    strb = 4'hf;
    mismatches = 0;
    checks_done = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(cmp_out, 2'h0);
    for (int i = 0; i < TMCU_NREG; i++) rd(TMCU_OFS[i], 8'h00, OK);
    rd(8'h1c, 8'h00, TMCU_RESP_SLVERR);
    wr(8'h1c, 8'h55, TMCU_RESP_SLVERR);
    // Stopped counter ignores pin edges
    wr(A_CNT, 8'h5a, OK);
    u_pins.pulse(2);
    rd(A_CNT, 8'h5a, OK);
    rd(A_FLG, 8'h00, OK);
    // Normal mode wrap; match flag only on the tick after equality
    wr(A_MSK, 8'h07, OK);
    wr(A_CPA, 8'h00, OK);
    wr(A_CPB, 8'h01, OK);
    wr(A_CNT, 8'hfe, OK);
    wr(A_CB, 8'h07, OK);
    u_pins.pulse(3);
    rd(A_CNT, 8'h01, OK);
    rd(A_FLG, 8'h03, OK);
    chk(irq, 3'h3);
    wr(A_MSK, 8'h02, OK);
    repeat (2) @(posedge aclk);
    chk(irq, 3'h2);
    wr(A_FLG, 8'h01, OK);
    rd(A_FLG, 8'h02, OK);
    int_ack <= 3'h2;
    @(posedge aclk);
    int_ack <= 3'h0;
    rd(A_FLG, 8'h00, OK);
    // Counter write equal to compare hides the next match
    wr(A_CPA, 8'h10, OK);
    wr(A_CNT, 8'h10, OK);
    u_pins.pulse(1);
    rd(A_CNT, 8'h11, OK);
    rd(A_FLG, 8'h00, OK);
    // Clear-on-match: 0,1,2,3,0,1
    wr(A_CA, 8'h02, OK);
    wr(A_CPA, 8'h03, OK);
    wr(A_CNT, 8'h00, OK);
    u_pins.pulse(5);
    rd(A_CNT, 8'h01, OK);
    rd(A_FLG, 8'h06, OK);
    // Fast mode with fixed top
    wr(A_FLG, 8'h07, OK);
    wr(A_CA, 8'h03, OK);
    wr(A_CNT, 8'hfe, OK);
    u_pins.pulse(3);
    rd(A_CNT, 8'h01, OK);
    rd(A_FLG, 8'h01, OK);
    // Fast mode with top from compare A; new top only after old top
    wr(A_FLG, 8'h07, OK);
    wr(A_CB, 8'h0f, OK);
    wr(A_CPA, 8'h08, OK);
    rd(A_CPA, 8'h08, OK);
    u_pins.pulse(3);
    u_pins.pulse(6);
    rd(A_CNT, 8'h06, OK);
    // Old top 3 matched A and wrapped; count 1 matched B
    rd(A_FLG, 8'h07, OK);
    wr(A_FLG, 8'h07, OK);
    // Forced matches in normal mode follow the output mode at once
    wr(A_CB, 8'h00, OK);
    wr(A_CA, 8'h40, OK);
    // Enable follows the control write by one edge
    @(posedge aclk);
    chk(cmp_en, 2'h1);
    wr(A_CB, 8'h80, OK);
    repeat (2) @(posedge aclk);
    chk(cmp_out, 2'h1);
    wr(A_CB, 8'h80, OK);
    repeat (2) @(posedge aclk);
    chk(cmp_out, 2'h0);
    wr(A_CA, 8'hc0, OK);
    wr(A_CB, 8'h80, OK);
    repeat (2) @(posedge aclk);
    chk(cmp_out, 2'h1);
    rd(A_FLG, 8'h00, OK);
    rd(A_CNT, 8'h06, OK);
    wr(A_CA, 8'hc3, OK);
    chk(cmp_out, 2'h1);
    // Falling-edge source
    wr(A_CB, 8'h06, OK);
    u_pins.pulse(2);
    rd(A_CNT, 8'h08, OK);
    // Clock enable low freezes synchroniser and counter
    ce <= 1'b0;
    u_pins.pulse(2);
    ce <= 1'b1;
    rd(A_CNT, 8'h08, OK);
    // Every-clock source: ticks at the four edges between the two landings
    wr(A_CNT, 8'h00, OK);
    wr(A_CB, 8'h01, OK);
    wr(A_CB, 8'h00, OK);
    rd(A_CNT, 8'h04, OK);
    // Byte strobe low: answered, no effect
    strb <= 4'h0;
    wr(A_CNT, 8'h33, OK);
    strb <= 4'hf;
    rd(A_CNT, 8'h04, OK);
    // Phase correct, top 0xff: fe, ff, fe, fd, fc
    wr(A_FLG, 8'h07, OK);
    wr(A_CA, 8'h01, OK);
    wr(A_CB, 8'h07, OK);
    // Written while counting up, never bottom on the way down
    wr(A_CNT, 8'hfe, OK);
    u_pins.pulse(4);
    rd(A_CNT, 8'hfc, OK);
    rd(A_FLG, 8'h00, OK);
    results();
  end
endmodule
`default_nettype wire
